// [hw/vtpg_top.sv]
// Video test pattern generator feeding the CSI-2 transmit logic
//
// Strobed register access and the register addresses are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
// ============================================================
// Summary of operation
// - Colour bar or fixed colour pattern, chosen by configuration register.
// - Eight bars carry AA,33,F0,7F,55,CC,0F,80 in that order.
// - Last bar stretches to fill the rest of the line.
// - Bar count per line selectable as 1, 2, 4 or 8.
// - Each active line carries exactly the programmed byte count.
// - Next bar value starts after the programmed bar width in bytes.
// - Line packets carry the programmed data type and channel; frame start and end packets carry only the programmed channel.
// - Active line count and total line count per frame are programmable.
// - Line starts spaced by the programmed line period count.
// - Front porch blank lines come before the frame end packet.
// - Back porch blank lines follow the frame start packet.
// - Runs on the transmit clock and emits complete packet data.
// - Fixed mode repeats a programmed byte block with same geometry.
// - Fixed mode alternates block and its complement bar by bar.
// - Fixed block length 1 to 16 bytes, repeated cyclically.
// - Sixteen byte registers hold the fixed block contents.
// - Line period counted in units of forty channel bit times.
module vtpg_top #(
	parameter int UNIT_CYC = vtpg_pkg::LINE_UNIT_CYC
) (
	// Clock and reset
	input wire logic SYS_CLK,
	input wire logic RSTN,
	// Register port
	input wire logic [7:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [7:0] REG_RDATA,
	// Packet stream to the transmitter
	output logic PKT_SOP,
	output logic PKT_VALID,
	output logic [7:0] PKT_DATA,
	output logic PKT_EOP,
	input wire logic PKT_READY
);
	initial begin
		if (UNIT_CYC < 1) begin
			$error("UNIT_CYC must be at least one");
		end
	end

	// ==========================================================
	// Configuration registers
	logic [7:0] ctl_r, ctl_nxt, cfg_r, cfg_nxt, csi_r, csi_nxt;
	logic [15:0] lsize_r, lsize_nxt, bsize_r, bsize_nxt;
	logic [15:0] act_r, act_nxt, tot_r, tot_nxt, lpd_r, lpd_nxt;
	logic [7:0] vbp_r, vbp_nxt, vfp_r, vfp_nxt;
	logic [4:0] blk_r, blk_nxt;
	logic [7:0] fix_r [16];
	logic [7:0] fix_nxt [16];
	logic [7:0] rdata_r, rdata_nxt;
	logic busy_r;

	always_comb begin
		ctl_nxt = ctl_r;
		cfg_nxt = cfg_r;
		csi_nxt = csi_r;
		lsize_nxt = lsize_r;
		bsize_nxt = bsize_r;
		act_nxt = act_r;
		tot_nxt = tot_r;
		lpd_nxt = lpd_r;
		vbp_nxt = vbp_r;
		vfp_nxt = vfp_r;
		blk_nxt = blk_r;
		fix_nxt = fix_r;
		if (REG_WR) begin
			if (REG_ADDR == vtpg_pkg::OFS_CTL) begin
				ctl_nxt = REG_WDATA;
			end else if (REG_ADDR == vtpg_pkg::OFS_CFG) begin
				cfg_nxt = REG_WDATA;
			end else if (REG_ADDR == vtpg_pkg::OFS_CSI_ID) begin
				csi_nxt = REG_WDATA;
			end else if (REG_ADDR == vtpg_pkg::OFS_LSIZE1) begin
				lsize_nxt[15:8] = REG_WDATA;
			end else if (REG_ADDR == vtpg_pkg::OFS_LSIZE0) begin
				lsize_nxt[7:0] = REG_WDATA;
			end else if (REG_ADDR == vtpg_pkg::OFS_BSIZE1) begin
				bsize_nxt[15:8] = REG_WDATA;
			end else if (REG_ADDR == vtpg_pkg::OFS_BSIZE0) begin
				bsize_nxt[7:0] = REG_WDATA;
			end else if (REG_ADDR == vtpg_pkg::OFS_ACT1) begin
				act_nxt[15:8] = REG_WDATA;
			end else if (REG_ADDR == vtpg_pkg::OFS_ACT0) begin
				act_nxt[7:0] = REG_WDATA;
			end else if (REG_ADDR == vtpg_pkg::OFS_TOT1) begin
				tot_nxt[15:8] = REG_WDATA;
			end else if (REG_ADDR == vtpg_pkg::OFS_TOT0) begin
				tot_nxt[7:0] = REG_WDATA;
			end else if (REG_ADDR == vtpg_pkg::OFS_LPD1) begin
				lpd_nxt[15:8] = REG_WDATA;
			end else if (REG_ADDR == vtpg_pkg::OFS_LPD0) begin
				lpd_nxt[7:0] = REG_WDATA;
			end else if (REG_ADDR == vtpg_pkg::OFS_VBP) begin
				vbp_nxt = REG_WDATA;
			end else if (REG_ADDR == vtpg_pkg::OFS_VFP) begin
				vfp_nxt = REG_WDATA;
			end else if (REG_ADDR == vtpg_pkg::OFS_BLKLEN) begin
				// Zero or above sixteen is clamped to a usable length
				if (REG_WDATA == 8'h00) begin
					blk_nxt = 5'h01;
				end else if (REG_WDATA > 8'h10) begin
					blk_nxt = 5'h10;
				end else begin
					blk_nxt = REG_WDATA[4:0];
				end
			end else if (REG_ADDR[7:4] == vtpg_pkg::OFS_FIXED[7:4]) begin
				fix_nxt[REG_ADDR[3:0]] = REG_WDATA;
			end
		end
		rdata_nxt = 8'h00;
		if (REG_RD) begin
			if (REG_ADDR == vtpg_pkg::OFS_CTL) begin
				rdata_nxt = ctl_r;
			end else if (REG_ADDR == vtpg_pkg::OFS_CFG) begin
				rdata_nxt = cfg_r;
			end else if (REG_ADDR == vtpg_pkg::OFS_CSI_ID) begin
				rdata_nxt = csi_r;
			end else if (REG_ADDR == vtpg_pkg::OFS_LSIZE1) begin
				rdata_nxt = lsize_r[15:8];
			end else if (REG_ADDR == vtpg_pkg::OFS_LSIZE0) begin
				rdata_nxt = lsize_r[7:0];
			end else if (REG_ADDR == vtpg_pkg::OFS_BSIZE1) begin
				rdata_nxt = bsize_r[15:8];
			end else if (REG_ADDR == vtpg_pkg::OFS_BSIZE0) begin
				rdata_nxt = bsize_r[7:0];
			end else if (REG_ADDR == vtpg_pkg::OFS_ACT1) begin
				rdata_nxt = act_r[15:8];
			end else if (REG_ADDR == vtpg_pkg::OFS_ACT0) begin
				rdata_nxt = act_r[7:0];
			end else if (REG_ADDR == vtpg_pkg::OFS_TOT1) begin
				rdata_nxt = tot_r[15:8];
			end else if (REG_ADDR == vtpg_pkg::OFS_TOT0) begin
				rdata_nxt = tot_r[7:0];
			end else if (REG_ADDR == vtpg_pkg::OFS_LPD1) begin
				rdata_nxt = lpd_r[15:8];
			end else if (REG_ADDR == vtpg_pkg::OFS_LPD0) begin
				rdata_nxt = lpd_r[7:0];
			end else if (REG_ADDR == vtpg_pkg::OFS_VBP) begin
				rdata_nxt = vbp_r;
			end else if (REG_ADDR == vtpg_pkg::OFS_VFP) begin
				rdata_nxt = vfp_r;
			end else if (REG_ADDR == vtpg_pkg::OFS_STATUS) begin
				rdata_nxt = {7'h00, busy_r};
			end else if (REG_ADDR == vtpg_pkg::OFS_BLKLEN) begin
				rdata_nxt = {3'h0, blk_r};
			end else if (REG_ADDR[7:4] == vtpg_pkg::OFS_FIXED[7:4]) begin
				rdata_nxt = fix_r[REG_ADDR[3:0]];
			end
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RSTN) begin
			ctl_r <= vtpg_pkg::RST_CTL;
			cfg_r <= vtpg_pkg::RST_CFG;
			csi_r <= vtpg_pkg::RST_CSI_ID;
			lsize_r <= vtpg_pkg::RST_LSIZE;
			bsize_r <= vtpg_pkg::RST_BSIZE;
			act_r <= vtpg_pkg::RST_ACT;
			tot_r <= vtpg_pkg::RST_TOT;
			lpd_r <= vtpg_pkg::RST_LPD;
			vbp_r <= vtpg_pkg::RST_VBP;
			vfp_r <= vtpg_pkg::RST_VFP;
			blk_r <= vtpg_pkg::RST_BLKLEN;
			for (int i = 0; i < 16; i++) begin
				fix_r[i] <= 8'h00;
			end
			rdata_r <= 8'h00;
		end else begin
			ctl_r <= ctl_nxt;
			cfg_r <= cfg_nxt;
			csi_r <= csi_nxt;
			lsize_r <= lsize_nxt;
			bsize_r <= bsize_nxt;
			act_r <= act_nxt;
			tot_r <= tot_nxt;
			lpd_r <= lpd_nxt;
			vbp_r <= vbp_nxt;
			vfp_r <= vfp_nxt;
			blk_r <= blk_nxt;
			fix_r <= fix_nxt;
			rdata_r <= rdata_nxt;
		end
	end
	assign REG_RDATA = rdata_r;

	// ==========================================================
	// Frame sequencer and byte generator
	vtpg_pkg::vtpg_state_t st_r, st_nxt;
	vtpg_pkg::vtpg_phase_t ph_r, ph_nxt;
	logic [15:0] line_r, line_nxt, pcnt_r, pcnt_nxt, unit_r, unit_nxt;
	logic [15:0] byte_r, byte_nxt, bbyte_r, bbyte_nxt;
	logic [15:0] ln_in_ph_r, ln_in_ph_nxt;
	logic [2:0] bar_r, bar_nxt;
	logic [1:0] hdr_r, hdr_nxt;
	logic [3:0] bpos_r, bpos_nxt;
	logic sop_r, sop_nxt, vld_r, vld_nxt, eop_r, eop_nxt;
	logic [7:0] dat_r, dat_nxt;
	logic tick, take, fixed_mode;
	logic [2:0] bar_max;

	// Header byte: channel and data type, then 16-bit word count
	function automatic logic [7:0] hdr_byte(input logic [1:0] idx,
		input logic [7:0] di, input logic [15:0] wc);
		case (idx)
			2'd0: hdr_byte = di;
			2'd1: hdr_byte = wc[7:0];
			default: hdr_byte = wc[15:8];
		endcase
	endfunction

	assign fixed_mode = cfg_r[vtpg_pkg::CFG_FIXED_BIT];
	// Bar count field: 0,1,2,3 selects 1,2,4,8 bars
	always_comb begin
		case (cfg_r[vtpg_pkg::CFG_BARS_LSB +: 2])
			2'd0: bar_max = 3'd0;
			2'd1: bar_max = 3'd1;
			2'd2: bar_max = 3'd3;
			default: bar_max = 3'd7;
		endcase
	end
	// Stalls hold header and payload bytes alike; period counting never pauses
	assign take = !vld_r || PKT_READY;
	assign tick = (unit_r == 16'(UNIT_CYC - 1));

	always_comb begin
		st_nxt = st_r;
		ph_nxt = ph_r;
		line_nxt = line_r;
		pcnt_nxt = pcnt_r;
		unit_nxt = tick ? 16'h0000 : unit_r + 16'h0001;
		byte_nxt = byte_r;
		bbyte_nxt = bbyte_r;
		ln_in_ph_nxt = ln_in_ph_r;
		bar_nxt = bar_r;
		hdr_nxt = hdr_r;
		bpos_nxt = bpos_r;
		sop_nxt = take ? 1'b0 : sop_r;
		eop_nxt = take ? 1'b0 : eop_r;
		vld_nxt = take ? 1'b0 : vld_r;
		dat_nxt = dat_r;
		if (tick && st_r != vtpg_pkg::ST_IDLE) begin
			pcnt_nxt = pcnt_r + 16'h0001;
		end
		case (st_r)
			vtpg_pkg::ST_IDLE: begin
				if (ctl_r[vtpg_pkg::CTL_EN_BIT]) begin
					st_nxt = vtpg_pkg::ST_FS;
					line_nxt = 16'h0000;
					pcnt_nxt = 16'h0000;
					// Restart the unit divider so the first slot is full length
					unit_nxt = 16'h0000;
					hdr_nxt = 2'd0;
				end
			end
			vtpg_pkg::ST_FS, vtpg_pkg::ST_FE, vtpg_pkg::ST_HDR: begin
				if (take) begin
					// Short packets carry the frame number 1 as data
					vld_nxt = 1'b1;
					sop_nxt = (hdr_r == 2'd0);
					if (st_r == vtpg_pkg::ST_HDR) begin
						dat_nxt = hdr_byte(hdr_r, csi_r, lsize_r);
					end else begin
						dat_nxt = hdr_byte(hdr_r,
							{csi_r[7:6], st_r == vtpg_pkg::ST_FE ?
							vtpg_pkg::DT_FRAME_END :
							vtpg_pkg::DT_FRAME_START},
							16'h0001);
					end
					hdr_nxt = hdr_r + 2'd1;
					if (hdr_r == 2'd2) begin
						hdr_nxt = 2'd0;
						byte_nxt = 16'h0000;
						bbyte_nxt = 16'h0000;
						bar_nxt = 3'd0;
						bpos_nxt = 4'h0;
						if (st_r == vtpg_pkg::ST_HDR) begin
							st_nxt = vtpg_pkg::ST_DATA;
							eop_nxt = (lsize_r == 16'h0000);
							if (lsize_r == 16'h0000) begin
								st_nxt = vtpg_pkg::ST_WAIT;
							end
						end else begin
							eop_nxt = 1'b1;
							st_nxt = vtpg_pkg::ST_WAIT;
						end
						if (st_r == vtpg_pkg::ST_FS) begin
							// Porch count of zero falls through at the first slot end
							ph_nxt = vtpg_pkg::PH_VBP;
							ln_in_ph_nxt = 16'h0000;
						end
						if (st_r == vtpg_pkg::ST_FE) begin
							ph_nxt = vtpg_pkg::PH_IDLE;
						end
					end
				end
			end
			vtpg_pkg::ST_DATA: begin
				if (take) begin
					vld_nxt = 1'b1;
					if (fixed_mode) begin
						dat_nxt = bar_r[0] ? ~fix_r[bpos_r] :
							fix_r[bpos_r];
						bpos_nxt = (bpos_r == 4'(blk_r - 5'd1)) ? 4'h0 :
							bpos_r + 4'h1;
					end else begin
						dat_nxt = vtpg_pkg::BAR_BYTES[{bar_r, 3'b000} +: 8];
					end
					byte_nxt = byte_r + 16'h0001;
					bbyte_nxt = bbyte_r + 16'h0001;
					// Last bar holds its value to the end of line
					if (bbyte_r + 16'h0001 >= bsize_r &&
						bar_r != bar_max) begin
						bbyte_nxt = 16'h0000;
						bar_nxt = bar_r + 3'd1;
						bpos_nxt = 4'h0;
					end
					if (byte_r + 16'h0001 == lsize_r) begin
						eop_nxt = 1'b1;
						st_nxt = vtpg_pkg::ST_WAIT;
					end
				end
			end
			default: begin
				// ST_WAIT: next line slot starts when the period elapses
				if (tick && pcnt_r + 16'h0001 >= lpd_r) begin
					pcnt_nxt = 16'h0000;
					line_nxt = line_r + 16'h0001;
					ln_in_ph_nxt = ln_in_ph_r + 16'h0001;
					hdr_nxt = 2'd0;
					case (ph_r)
						vtpg_pkg::PH_VBP: begin
							if (ln_in_ph_r >= {8'h00, vbp_r}) begin
								ph_nxt = vtpg_pkg::PH_ACT;
								ln_in_ph_nxt = 16'h0000;
								st_nxt = vtpg_pkg::ST_HDR;
							end
						end
						vtpg_pkg::PH_ACT: begin
							if (ln_in_ph_r + 16'h0001 >= act_r) begin
								ph_nxt = vtpg_pkg::PH_VFP;
								ln_in_ph_nxt = 16'h0000;
								if (vfp_r == 8'h00) begin
									st_nxt = vtpg_pkg::ST_FE;
								end
							end else begin
								st_nxt = vtpg_pkg::ST_HDR;
							end
						end
						vtpg_pkg::PH_VFP: begin
							if (ln_in_ph_r + 16'h0001 >= {8'h00, vfp_r}) begin
								st_nxt = vtpg_pkg::ST_FE;
							end
						end
						default: begin
							if (line_r + 16'h0001 >= tot_r) begin
								// Back-to-back frames keep the slot grid unbroken
								line_nxt = 16'h0000;
								st_nxt = ctl_r[vtpg_pkg::CTL_EN_BIT] ?
									vtpg_pkg::ST_FS : vtpg_pkg::ST_IDLE;
							end
						end
					endcase
				end
			end
		endcase
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RSTN) begin
			st_r <= vtpg_pkg::ST_IDLE;
			ph_r <= vtpg_pkg::PH_IDLE;
			line_r <= 16'h0000;
			pcnt_r <= 16'h0000;
			unit_r <= 16'h0000;
			byte_r <= 16'h0000;
			bbyte_r <= 16'h0000;
			ln_in_ph_r <= 16'h0000;
			bar_r <= 3'd0;
			hdr_r <= 2'd0;
			bpos_r <= 4'h0;
			sop_r <= 1'b0;
			vld_r <= 1'b0;
			eop_r <= 1'b0;
			dat_r <= 8'h00;
			busy_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			ph_r <= ph_nxt;
			line_r <= line_nxt;
			pcnt_r <= pcnt_nxt;
			unit_r <= unit_nxt;
			byte_r <= byte_nxt;
			bbyte_r <= bbyte_nxt;
			ln_in_ph_r <= ln_in_ph_nxt;
			bar_r <= bar_nxt;
			hdr_r <= hdr_nxt;
			bpos_r <= bpos_nxt;
			sop_r <= sop_nxt;
			vld_r <= vld_nxt;
			eop_r <= eop_nxt;
			dat_r <= dat_nxt;
			busy_r <= (st_nxt != vtpg_pkg::ST_IDLE);
		end
	end
	assign PKT_SOP = sop_r;
	assign PKT_VALID = vld_r;
	assign PKT_DATA = dat_r;
	assign PKT_EOP = eop_r;
endmodule
`default_nettype wire

// [hw/vtpg_pkg.sv]
// Package for the video test pattern generator: constants and types
package vtpg_pkg;
	// ==========================================================
	// Register offsets of the indirect pattern generator page
	localparam logic [7:0] OFS_CTL = 8'h01;
	localparam logic [7:0] OFS_CFG = 8'h02;
	localparam logic [7:0] OFS_CSI_ID = 8'h03;
	localparam logic [7:0] OFS_LSIZE1 = 8'h04;
	localparam logic [7:0] OFS_LSIZE0 = 8'h05;
	localparam logic [7:0] OFS_BSIZE1 = 8'h06;
	localparam logic [7:0] OFS_BSIZE0 = 8'h07;
	localparam logic [7:0] OFS_ACT1 = 8'h08;
	localparam logic [7:0] OFS_ACT0 = 8'h09;
	localparam logic [7:0] OFS_TOT1 = 8'h0a;
	localparam logic [7:0] OFS_TOT0 = 8'h0b;
	localparam logic [7:0] OFS_LPD1 = 8'h0c;
	localparam logic [7:0] OFS_LPD0 = 8'h0d;
	localparam logic [7:0] OFS_VBP = 8'h0e;
	localparam logic [7:0] OFS_VFP = 8'h0f;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [7:0] OFS_BLKLEN = 8'h11;
	localparam logic [7:0] OFS_FIXED = 8'h20;
	// ==========================================================
	// Field positions
	localparam int CTL_EN_BIT = 0;
	localparam int CFG_FIXED_BIT = 7;
	localparam int CFG_BARS_LSB = 4;
	// ==========================================================
	// Reset values
	localparam logic [7:0] RST_CFG = 8'h33;
	localparam logic [15:0] RST_LSIZE = 16'h0010;
	localparam logic [15:0] RST_BSIZE = 16'h0002;
	localparam logic [15:0] RST_ACT = 16'h0004;
	localparam logic [15:0] RST_TOT = 16'h0008;
	localparam logic [15:0] RST_LPD = 16'h0040;
	localparam logic [7:0] RST_CSI_ID = 8'h24;
	localparam logic [4:0] RST_BLKLEN = 5'h03;
	localparam logic [7:0] RST_CTL = 8'h00;
	localparam logic [7:0] RST_VBP = 8'h01;
	localparam logic [7:0] RST_VFP = 8'h01;
	// ==========================================================
	// Packet codes and timing
	localparam logic [5:0] DT_FRAME_START = 6'h00;
	localparam logic [5:0] DT_FRAME_END = 6'h01;
	localparam int LINE_UNIT_NS = 10;
	localparam int CLK_PERIOD_NS = 20;
	localparam int LINE_UNIT_CYC = (LINE_UNIT_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	// Bar values of the reference pattern, first bar in the low byte
	localparam logic [63:0] BAR_BYTES = 64'h800f_cc55_7ff0_33aa;
	typedef enum logic [2:0] {
		ST_IDLE, ST_FS, ST_WAIT, ST_HDR, ST_DATA, ST_FE
	} vtpg_state_t;
	typedef enum logic [1:0] {
		PH_VBP, PH_ACT, PH_VFP, PH_IDLE
	} vtpg_phase_t;
endpackage

// [tb/vtpg_sink.sv]
// Transmitter-side sink model for the packet stream
`timescale 1ns/1ns
`default_nettype none
module vtpg_sink (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Control and handshake
	input wire logic stall,
	output logic ready
);
	logic [1:0] cnt_r;
	logic [1:0] cnt_nxt;
	// When stalling, accept only one cycle in three
	always_comb begin
		cnt_nxt = (cnt_r == 2'h2) ? 2'h0 : cnt_r + 2'h1;
	end
	always_ff @(posedge clk) begin
		if (!rstn) begin
			cnt_r <= 2'h0;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end
	assign ready = !stall || cnt_r == 2'h2;
endmodule
`default_nettype wire

// [tb/vtpg_props.sv]
// Port checker for the pattern generator, bound to its top module
`timescale 1ns/1ns
`default_nettype none
module vtpg_props #(
	parameter int UNIT_CYC = 1
) (
	// Clock and reset
	input wire logic SYS_CLK,
	input wire logic RSTN,
	// Register port
	input wire logic [7:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [7:0] REG_RDATA,
	// Packet stream
	input wire logic PKT_SOP,
	input wire logic PKT_VALID,
	input wire logic [7:0] PKT_DATA,
	input wire logic PKT_EOP,
	input wire logic PKT_READY
);
	logic en_r;
	logic en_nxt;
	// ==========================================================
	// Enable history; only reset forgets it
	always_comb begin
		en_nxt = en_r;
		if (REG_WR && REG_ADDR == vtpg_pkg::OFS_CTL && REG_WDATA[0]) begin
			en_nxt = 1'b1;
		end
	end
	always_ff @(posedge SYS_CLK) begin
		if (!RSTN) begin
			en_r <= 1'b0;
		end else begin
			en_r <= en_nxt;
		end
	end
	// ==========================================================
	// Properties
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RSTN);
	sequence s_stall;
		PKT_VALID && !PKT_READY;
	endsequence
	sequence s_last;
		PKT_VALID && PKT_READY && PKT_EOP;
	endsequence
	property p_hold;
		s_stall |=> PKT_VALID && $stable(PKT_DATA) && $stable(PKT_SOP)
			&& $stable(PKT_EOP);
	endproperty
	property p_next_sop;
		s_last |=> !PKT_VALID || PKT_SOP;
	endproperty
	property p_sop_valid;
		PKT_SOP || PKT_EOP |-> PKT_VALID;
	endproperty
	property p_min_len;
		PKT_VALID && PKT_READY && PKT_SOP |-> !PKT_EOP;
	endproperty
	property p_rd_idle;
		!REG_RD |=> REG_RDATA == 8'h00;
	endproperty
	property p_unmapped;
		REG_RD && REG_ADDR == 8'h40 |=> REG_RDATA == 8'h00;
	endproperty
	property p_status;
		REG_RD && REG_ADDR == vtpg_pkg::OFS_STATUS |=> REG_RDATA[7:1] == 7'h00;
	endproperty
	property p_no_start;
		!en_r |-> !PKT_VALID;
	endproperty
	a_hold: assert property (p_hold) else $error("stalled byte changed");
	a_next_sop: assert property (p_next_sop) else $error("no sop");
	a_sop_valid: assert property (p_sop_valid) else $error("flag alone");
	a_min_len: assert property (p_min_len) else $error("short pkt");
	a_rd_idle: assert property (p_rd_idle) else $error("rdata not 0");
	a_unmapped: assert property (p_unmapped) else $error("hole read");
	a_status: assert property (p_status) else $error("status bits");
	a_no_start: assert property (p_no_start) else $error("unasked");
endmodule
bind vtpg_top vtpg_props #(.UNIT_CYC(UNIT_CYC)) u_props (
	.SYS_CLK(SYS_CLK), .RSTN(RSTN), .REG_ADDR(REG_ADDR),
	.REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
	.REG_RDATA(REG_RDATA), .PKT_SOP(PKT_SOP), .PKT_VALID(PKT_VALID),
	.PKT_DATA(PKT_DATA), .PKT_EOP(PKT_EOP), .PKT_READY(PKT_READY));
`default_nettype wire

// [tb/vtpg_top_tb.sv]
// Self-checking testbench for the video test pattern generator
`timescale 1ns/1ns
`default_nettype none
module vtpg_top_tb;
	localparam int UNIT = 2;
	logic clk = 1'b0;
	logic rstn, wr_s, rd_s, stall, sop, vld, eop, rdy, pend = 1'b0;
	logic [7:0] adr, wd, rdat, pd;
	int err_count = 0;
	int num_checks = 0;
	int cyc = 0;
	logic [9:0] q[$];
	int tq[$];
	logic [7:0] fix [16];
	logic [7:0] bars [8] = '{8'haa, 8'h33, 8'hf0, 8'h7f,
		8'h55, 8'hcc, 8'h0f, 8'h80};
	always #10 clk = ~clk;
	vtpg_top #(.UNIT_CYC(UNIT)) DUT (.SYS_CLK(clk), .RSTN(rstn),
		.REG_ADDR(adr), .REG_WDATA(wd), .REG_WR(wr_s), .REG_RD(rd_s),
		.REG_RDATA(rdat), .PKT_SOP(sop), .PKT_VALID(vld), .PKT_DATA(pd),
		.PKT_EOP(eop), .PKT_READY(rdy));
	vtpg_sink u_sink (.clk(clk), .rstn(rstn), .stall(stall), .ready(rdy));
	// Start times are taken when a header is first offered, not accepted
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (vld && rdy) q.push_back({sop, eop, pd});
		if (vld && sop && !pend) tq.push_back(cyc);
		pend <= vld && sop && !rdy;
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chki(input int got, input int exp);
		chk(got[15:0], exp[15:0]);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		adr <= a;
		wd <= d;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		adr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		@(posedge clk);
		d = rdat;
	endtask
	task automatic w16(input logic [7:0] a, input int v);
		wr(a, v[15:8]);
		wr(a + 8'h01, v[7:0]);
	endtask
	task automatic run(input logic [7:0] cfg, csi, input int lsz, bsz,
		act, tot, lpd, vbp, vfp, blk, nfr);
		int n, nb, b, p, s;
		logic [7:0] v, d;
		logic [9:0] e[$];
		wr(vtpg_pkg::OFS_CFG, cfg);
		wr(vtpg_pkg::OFS_CSI_ID, csi);
		w16(vtpg_pkg::OFS_LSIZE1, lsz);
		w16(vtpg_pkg::OFS_BSIZE1, bsz);
		w16(vtpg_pkg::OFS_ACT1, act);
		w16(vtpg_pkg::OFS_TOT1, tot);
		w16(vtpg_pkg::OFS_LPD1, lpd);
		wr(vtpg_pkg::OFS_VBP, vbp[7:0]);
		wr(vtpg_pkg::OFS_VFP, vfp[7:0]);
		wr(vtpg_pkg::OFS_BLKLEN, blk[7:0]);
		q.delete();
		tq.delete();
		wr(vtpg_pkg::OFS_CTL, 8'h01);
		n = 0;
		while (tq.size() < 1 + (nfr - 1) * (act + 2) && n < 20000) begin
			@(posedge clk);
			n++;
		end
		rd(vtpg_pkg::OFS_STATUS, d);
		chk(16'(d), 16'h1);
		wr(vtpg_pkg::OFS_CTL, 8'h00);
		n = 0;
		do begin
			rd(vtpg_pkg::OFS_STATUS, d);
			n++;
		end while (d[0] !== 1'b0 && n < 5000);
		p = lpd * UNIT;
		repeat (tot * p) @(posedge clk);
		nb = 1 << cfg[5:4];
		for (int f = 0; f < nfr; f++) begin
			e.push_back({2'b10, csi[7:6], vtpg_pkg::DT_FRAME_START});
			e.push_back(10'h001);
			e.push_back(10'h100);
			for (int l = 0; l < act; l++) begin
				e.push_back({2'b10, csi});
				e.push_back({2'b00, lsz[7:0]});
				e.push_back({2'b00, lsz[15:8]});
				for (int j = 0; j < lsz; j++) begin
					b = (j / bsz > nb - 1) ? nb - 1 : j / bsz;
					v = cfg[7] ? fix[(j - b * bsz) % blk] : bars[b];
					if (cfg[7] && b % 2 == 1) v = ~v;
					e.push_back({1'b0, j == lsz - 1, v});
				end
			end
			e.push_back({2'b10, csi[7:6], vtpg_pkg::DT_FRAME_END});
			e.push_back(10'h001);
			e.push_back(10'h100);
		end
		chki(q.size(), e.size());
		for (int k = 0; k < e.size() && k < q.size(); k++)
			chk(16'(q[k]), 16'(e[k]));
		chki(tq.size(), nfr * (act + 2));
		if (tq.size() == nfr * (act + 2)) begin
			for (int f = 0; f < nfr; f++) begin
				s = f * (act + 2);
				chki(tq[s + 1] - tq[s], (vbp + 1) * p);
				chki(tq[s + act + 1] - tq[s + act], (vfp + 1) * p);
				if (act > 1) chki(tq[s + 2] - tq[s + 1], p);
			end
			if (nfr > 1) chki(tq[act + 2] - tq[0], tot * p);
		end
	endtask
	task automatic t_regs;
		logic [7:0] d;
		logic [7:0] a [19] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06,
			8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e,
			8'h0f, 8'h10, 8'h11, 8'h20, 8'h40};
		logic [7:0] x [19] = '{8'h00, 8'h33, 8'h24, 8'h00, 8'h10, 8'h00,
			8'h02, 8'h00, 8'h04, 8'h00, 8'h08, 8'h00, 8'h40, 8'h01,
			8'h01, 8'h00, 8'h03, 8'h00, 8'h00};
		for (int i = 0; i < 19; i++) begin
			rd(a[i], d);
			chk(16'(d), 16'(x[i]));
		end
		for (int i = 0; i < 16; i++) begin
			fix[i] = {i[3:0], ~i[3:0]};
			wr(vtpg_pkg::OFS_FIXED + i[7:0], fix[i]);
		end
		wr(8'h40, 8'h5a);
		for (int i = 0; i < 16; i++) begin
			rd(vtpg_pkg::OFS_FIXED + i[7:0], d);
			chk(16'(d), 16'(fix[i]));
		end
		rd(8'h40, d);
		chk(16'(d), 16'h0);
		$display("t_regs done");
	endtask
	task automatic t_colour;
		// Slow sink: bytes must hold while line slots keep their pace
		stall <= 1'b1;
		run(8'h30, 8'h64, 19, 2, 2, 8, 50, 2, 1, 3, 2);
		stall <= 1'b0;
		$display("t_colour done");
	endtask
	task automatic t_bars;
		for (int k = 0; k < 4; k++)
			run({2'b00, k[1:0], 4'h3}, 8'h2b, 19, 2, 1, 5, 20, 0, 0, 3, 1);
		$display("t_bars done");
	endtask
	task automatic t_fixed;
		// First run: bar width a whole number of 3-byte blocks
		run(8'h90, 8'h1e, 15, 6, 2, 6, 20, 1, 1, 3, 1);
		run(8'h80, 8'h1e, 20, 4, 1, 4, 20, 0, 0, 16, 1);
		$display("t_fixed done");
	endtask
	task automatic conclude;
		$display("checks=%0d errors=%0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	initial begin
		repeat (60000) @(posedge clk);
		err_count++;
		$display("watchdog expired");
		conclude();
	end
	initial begin
		rstn <= 1'b0;
		wr_s <= 1'b0;
		rd_s <= 1'b0;
		adr <= 8'h00;
		wd <= 8'h00;
		stall <= 1'b0;
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		t_regs();
		t_colour();
		t_bars();
		t_fixed();
		conclude();
	end
endmodule
`default_nettype wire
